// ===== core/pbe_pkg.sv
package pbe_pkg;
  localparam int          LANES         = 4;
  localparam int          CLK_HZ        = 10_000_000;
  localparam int          OSC_DIV       = 12;
  localparam int          DIV_W         = 4;
  localparam logic [3:0]  DIV_LAST      = 4'hb;
  localparam logic [3:0]  DIV_HALF      = 4'h6;
  // axi-lite register map (byte addresses)
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;
  localparam logic [7:0]  ADDR_MASK     = 8'h08;
  localparam logic [7:0]  ADDR_LANES    = 8'h0c;
  // ctrl field positions
  localparam int          CTRL_FORCE    = 0;
  localparam int          CTRL_WGATE    = 1;
  localparam int          CTRL_PGATE    = 2;
  localparam logic [2:0]  CTRL_RESET    = 3'h0;
  // status / mask bit positions
  localparam int          ST_FAULT      = 0;
  localparam int          ST_MISMATCH   = 1;
  localparam int          ST_W          = 2;
  localparam logic [1:0]  MASK_RESET    = 2'h0;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage : pbe_pkg

// ===== core/ref_divider.sv
`timescale 1ns/1ps
`default_nettype none
module ref_divider (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  output logic                      div_tick,
  output logic                      divided_reference_clock
);
  import pbe_pkg::*;
  logic [DIV_W-1:0] count;
  logic [DIV_W-1:0] next_count;
  logic             next_divclk;

  always_comb begin
    next_count  = (count == DIV_LAST) ? '0 : count + 4'h1;
    next_divclk = (next_count < DIV_HALF);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count                   <= '0;
      divided_reference_clock <= 1'b0;
    end else begin
      count                   <= next_count;
      divided_reference_clock <= next_divclk;
    end
  end

  assign div_tick = (count == DIV_LAST);

  property p_div_period;
    @(posedge ref_clk) disable iff (rst)
      div_tick |=> !div_tick [*8] ##1 !div_tick [*3] ##1 div_tick;
  endproperty
  a_div_period: assert property (p_div_period) else $error("divider period not twelve");
endmodule : ref_divider
`default_nettype wire

// ===== core/parity_core.sv
`timescale 1ns/1ps
`default_nettype none
module parity_core #(
  parameter int LANES = 4
) (
  input  wire logic [LANES-1:0]     pp_upper,
  input  wire logic [LANES-1:0]     pp_lower,
  input  wire logic [LANES-1:0]     mp_held,
  input  wire logic [LANES-1:0]     lanes,
  output logic      [LANES-1:0]     byte_parity,
  output logic      [LANES-1:0]     gated_mismatch,
  output logic                      any_error
);
  genvar i;
  generate
    for (i = 0; i < LANES; i++) begin : g_lane
      assign byte_parity[i]    = pp_upper[i] ^ pp_lower[i];
      assign gated_mismatch[i] = (byte_parity[i] != mp_held[i]) & lanes[i];
    end
  endgenerate
  assign any_error = |gated_mismatch;
endmodule : parity_core
`default_nettype wire

// ===== core/parity_byte_enable_control.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - divide reference clock by twelve
// - flag cpu local bus cycles
// - hold lane selects through memory cycle
// - force input drives all lanes active
// - undriven force input reads deasserted
// - byte parity is xor of nibbles
// - compare read parity, flag mismatching bytes
// - capture parity on column/sample strobes
// - mask mismatches by lane select
// - or mismatches, latch fault when gated
// - drive write parity only when gated
// - undriven write gate keeps drivers off
module parity_byte_enable_control (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire logic [3:0]           cpu_lane_selects,
  input  wire logic                 memory_address_latch_enable,
  input  wire logic                 force_lane_selects,
  input  wire logic                 local_cycle_request,
  input  wire logic [3:0]           nibble_parity_upper,
  input  wire logic [3:0]           nibble_parity_lower,
  input  wire logic                 column_strobe,
  input  wire logic                 parity_sample_strobe,
  input  wire logic                 memory_read,
  input  wire logic                 parity_flag_gate,
  input  wire logic                 write_parity_drive_gate,
  input  wire logic [3:0]           memory_parity_bits_in,
  output logic      [3:0]           memory_parity_bits_out,
  output logic      [3:0]           memory_parity_bits_oe,
  output logic      [3:0]           latched_lane_selects,
  output logic                      latched_parity_fault,
  output logic                      local_cycle_flag,
  output logic                      divided_reference_clock,
  output logic                      irq,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic      [1:0]           s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic      [31:0]          s_axi_rdata,
  output logic      [1:0]           s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready
);
  import pbe_pkg::*;

  // pin gates are active high; a pull-up models as "pin low = inactive" externally,
  // so an open pin (0 here) disables. software ctrl bits may also assert them.
  logic [2:0]       ctrl;
  logic [ST_W-1:0]  status;
  logic [ST_W-1:0]  mask;
  logic [3:0]       lane_reg;
  logic [3:0]       mp_held;
  logic [3:0]       pp_up_held;
  logic [3:0]       pp_lo_held;
  logic             fault;
  logic             local_flag;
  logic [3:0]       next_lane_reg;
  logic [3:0]       next_mp_held;
  logic [3:0]       next_pp_up_held;
  logic [3:0]       next_pp_lo_held;
  logic             next_fault;
  logic             next_local_flag;
  logic [3:0]       byte_parity;
  logic [3:0]       gated_mismatch;
  logic             any_error;
  logic             force_eff;
  logic             wgate_eff;
  logic             pgate_eff;
  logic             capture;
  logic [3:0]       lanes_now;
  logic             div_tick;

  assign force_eff = force_lane_selects | ctrl[CTRL_FORCE];
  assign wgate_eff = write_parity_drive_gate | ctrl[CTRL_WGATE];
  assign pgate_eff = parity_flag_gate | ctrl[CTRL_PGATE];
  assign capture   = column_strobe & parity_sample_strobe;

  always_comb begin
    next_lane_reg   = memory_address_latch_enable ? cpu_lane_selects : lane_reg;
    next_mp_held    = capture ? memory_parity_bits_in : mp_held;
    next_pp_up_held = capture ? nibble_parity_upper : pp_up_held;
    next_pp_lo_held = capture ? nibble_parity_lower : pp_lo_held;
    next_local_flag = local_cycle_request;
    if (!pgate_eff) begin
      next_fault = 1'b0;
    end else begin
      next_fault = fault | (memory_read & any_error);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lane_reg   <= '0;
      mp_held    <= '0;
      pp_up_held <= '0;
      pp_lo_held <= '0;
      fault      <= 1'b0;
      local_flag <= 1'b0;
    end else begin
      lane_reg   <= next_lane_reg;
      mp_held    <= next_mp_held;
      pp_up_held <= next_pp_up_held;
      pp_lo_held <= next_pp_lo_held;
      fault      <= next_fault;
      local_flag <= next_local_flag;
    end
  end

  assign lanes_now            = force_eff ? '1 : lane_reg;
  assign latched_lane_selects = lanes_now;
  assign latched_parity_fault = fault;
  assign local_cycle_flag     = local_flag;

  parity_core #(.LANES(LANES)) u_core (
    .pp_upper       (pp_up_held),
    .pp_lower       (pp_lo_held),
    .mp_held        (mp_held),
    .lanes          (lanes_now),
    .byte_parity    (byte_parity),
    .gated_mismatch (gated_mismatch),
    .any_error      (any_error)
  );

  // write parity is combinational from live nibbles: hold time is the buffers'
  logic [3:0] wr_parity;
  assign wr_parity              = nibble_parity_upper ^ nibble_parity_lower;
  assign memory_parity_bits_out = wr_parity;
  assign memory_parity_bits_oe  = (wgate_eff & !memory_read) ? '1 : '0;

  ref_divider u_div (
    .ref_clk                 (ref_clk),
    .rst                     (rst),
    .div_tick                (div_tick),
    .divided_reference_clock (divided_reference_clock)
  );

  // status events: set wins over write-one-to-clear
  logic [ST_W-1:0] events;
  logic [ST_W-1:0] w1c;
  logic [ST_W-1:0] next_status;
  assign events = {pgate_eff & memory_read & any_error, next_fault & !fault};

  // axi-lite write: address and data taken in either order
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        bvalid;
  logic [1:0]  bresp;
  logic        next_aw_held;
  logic        next_w_held;
  logic [7:0]  next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0]  next_w_strb;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic [2:0]  next_ctrl;
  logic [ST_W-1:0] next_mask;
  logic        do_write;

  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready  = !w_held && !bvalid;
  assign do_write      = aw_held && w_held && !bvalid;

  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_ctrl    = ctrl;
    next_mask    = mask;
    w1c          = '0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_OKAY;
      unique case (aw_addr)
        ADDR_CTRL:   if (w_strb[0]) next_ctrl = w_data[2:0];
        ADDR_STATUS: if (w_strb[0]) w1c = w_data[ST_W-1:0];
        ADDR_MASK:   if (w_strb[0]) next_mask = w_data[ST_W-1:0];
        ADDR_LANES:  next_bresp = RESP_OKAY;
        default:     next_bresp = RESP_SLVERR;
      endcase
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    next_status = (status & ~w1c) | events;
  end

  // axi-lite read: one-cycle answer
  logic        rvalid;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  assign s_axi_arready = !rvalid;

  always_comb begin
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      next_rdata  = '0;
      unique case (s_axi_araddr)
        ADDR_CTRL:   next_rdata[2:0]      = ctrl;
        ADDR_STATUS: next_rdata[ST_W-1:0] = status;
        ADDR_MASK:   next_rdata[ST_W-1:0] = mask;
        ADDR_LANES:  next_rdata[7:0]      = {gated_mismatch, lanes_now};
        default:     next_rresp           = RESP_SLVERR;
      endcase
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      ctrl    <= CTRL_RESET;
      mask    <= MASK_RESET;
      status  <= '0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      ctrl    <= next_ctrl;
      mask    <= next_mask;
      status  <= next_status;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
    end
  end

  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp  = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata  = rdata;
  assign s_axi_rresp  = rresp;
  assign irq          = |(status & mask);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_force;
    force_lane_selects |-> latched_lane_selects == 4'hf;
  endproperty
  a_force: assert property (p_force) else $error("force did not set all lanes");
  property p_hold;
    !memory_address_latch_enable && !force_eff ##1 !memory_address_latch_enable && !force_eff
      |-> $stable(latched_lane_selects);
  endproperty
  a_hold: assert property (p_hold) else $error("lane selects moved while held");
  property p_follow;
    memory_address_latch_enable && !ctrl[CTRL_FORCE] && !force_lane_selects
      |=> force_eff || latched_lane_selects == $past(cpu_lane_selects);
  endproperty
  a_follow: assert property (p_follow) else $error("lane register did not follow");
  property p_local;
    local_cycle_request |=> local_cycle_flag;
  endproperty
  a_local: assert property (p_local) else $error("local flag missing");
  property p_wdrive;
    !write_parity_drive_gate && !ctrl[CTRL_WGATE] |-> memory_parity_bits_oe == 4'h0;
  endproperty
  a_wdrive: assert property (p_wdrive) else $error("parity driven without gate");
  property p_wval;
    memory_parity_bits_oe != 4'h0 |->
      memory_parity_bits_out == (nibble_parity_upper ^ nibble_parity_lower);
  endproperty
  a_wval: assert property (p_wval) else $error("wrong write parity");
  property p_fault_clear;
    !pgate_eff |=> !latched_parity_fault;
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("fault not cleared");
  property p_fault_set;
    pgate_eff && memory_read && any_error |=> latched_parity_fault;
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault not latched");
  property p_capture;
    capture |=> mp_held == $past(memory_parity_bits_in);
  endproperty
  a_capture: assert property (p_capture) else $error("parity not captured");
  property p_gate;
    (gated_mismatch & ~lanes_now) == 4'h0;
  endproperty
  a_gate: assert property (p_gate) else $error("unselected lane flagged");
  c_fault: cover property (latched_parity_fault);
  c_force: cover property (force_lane_selects && memory_address_latch_enable);
  c_irq:   cover property (irq);
endmodule : parity_byte_enable_control
`default_nettype wire

// ===== dv/slice_memory_model.sv
`timescale 1ns/1ps
`default_nettype none
module slice_memory_model (
  input  wire logic        ref_clk,
  input  wire logic [31:0] data,
  input  wire logic        mem_read,
  input  wire logic        store,
  input  wire logic [3:0]  flip,
  input  wire logic [3:0]  oe,
  input  wire logic [3:0]  out,
  output logic      [3:0]  pp_upper,
  output logic      [3:0]  pp_lower,
  output logic      [3:0]  mp_wire
);
  logic [3:0] stored = 4'h0;
  logic [3:0] last   = 4'h0;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pp_upper[i] = ^data[8*i+4 +: 4];
      pp_lower[i] = ^data[8*i +: 4];
      // no pull on the parity lines: a released line must not keep its last level
      mp_wire[i]  = oe[i] ? out[i] : (mem_read ? stored[i] ^ flip[i] : ~last[i]);
    end
  end
  always @(posedge ref_clk) begin
    last <= mp_wire;
    if (store) stored <= mp_wire;
  end
endmodule : slice_memory_model
`default_nettype wire

// ===== dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pbe_pkg::*;
  logic        ref_clk, rst, ale, frc, lreq, cstb, sstb, rd_cyc, pgate, wgate, store;
  logic [3:0]  sel, pp_u, pp_l, mp_in, mp_out, mp_oe, lanes, flip, fl, ln;
  logic        fault, lflag, divclk, irq, prev;
  logic [31:0] data, seed, w;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]  exp_b[$];
  logic [33:0] exp_r[$];
  logic [33:0] r_note;
  int          bad_count = 0;
  int          check_count = 0;
  int          i, hi, tr;

  parity_byte_enable_control uut (
    .ref_clk, .rst, .cpu_lane_selects(sel), .memory_address_latch_enable(ale),
    .force_lane_selects(frc), .local_cycle_request(lreq), .nibble_parity_upper(pp_u),
    .nibble_parity_lower(pp_l), .column_strobe(cstb), .parity_sample_strobe(sstb),
    .memory_read(rd_cyc), .parity_flag_gate(pgate), .write_parity_drive_gate(wgate),
    .memory_parity_bits_in(mp_in), .memory_parity_bits_out(mp_out),
    .memory_parity_bits_oe(mp_oe), .latched_lane_selects(lanes),
    .latched_parity_fault(fault), .local_cycle_flag(lflag),
    .divided_reference_clock(divclk), .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  slice_memory_model mem (.ref_clk, .data, .mem_read(rd_cyc), .store, .flip, .oe(mp_oe),
    .out(mp_out), .pp_upper(pp_u), .pp_lower(pp_l), .mp_wire(mp_in));

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_rand
  function automatic logic [3:0] byte_par(input logic [31:0] d);
    for (int k = 0; k < 4; k++) byte_par[k] = ^d[8*k +: 8];
  endfunction : byte_par
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic give_up;
    bad_count++;
    stop_test();
  endtask : give_up
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw_go, w_go, b_go;
    exp_b.push_back(r);
    @(posedge ref_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    b_go = 1'b0;
    for (int n = 0; n < 40 && !b_go; n++) begin
      @(negedge ref_clk);
      aw_go = s_axi_awvalid && s_axi_awready;
      w_go  = s_axi_wvalid && s_axi_wready;
      b_go  = s_axi_bvalid && s_axi_bready;
      @(posedge ref_clk);
      if (aw_go) s_axi_awvalid <= 1'b0;
      if (w_go) s_axi_wvalid <= 1'b0;
      if (b_go) s_axi_bready <= 1'b0;
    end
    if (!b_go) give_up();
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ar_go, r_go;
    exp_r.push_back({r, d});
    @(posedge ref_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    r_go = 1'b0;
    for (int n = 0; n < 40 && !r_go; n++) begin
      @(negedge ref_clk);
      ar_go = s_axi_arvalid && s_axi_arready;
      r_go  = s_axi_rvalid && s_axi_rready;
      @(posedge ref_clk);
      if (ar_go) s_axi_arvalid <= 1'b0;
      if (r_go) s_axi_rready <= 1'b0;
    end
    if (!r_go) give_up();
  endtask : axi_rd

  // responses are judged mid-cycle, where the handshake cycle is settled
  always @(negedge ref_clk) begin
    if (s_axi_bvalid && s_axi_bready && exp_b.size() > 0)
      check(32'(s_axi_bresp), 32'(exp_b.pop_front()));
    if (s_axi_rvalid && s_axi_rready && exp_r.size() > 0) begin
      r_note = exp_r.pop_front();
      check(32'(s_axi_rresp), 32'(r_note[33:32]));
      if (r_note[33:32] == RESP_OKAY) check(s_axi_rdata, r_note[31:0]);
    end
  end

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    rst = 1'b1;
    {ale, frc, lreq, cstb, sstb, rd_cyc, pgate, wgate, store} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, sel, flip, data, ln} = '0;
    seed = 32'hf902f0ab;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    check(32'(lanes), 32'h0);
    check(32'(fault), 32'h0);
    check(32'(irq), 32'h0);
    axi_rd(ADDR_CTRL, 32'h0, RESP_OKAY);
    axi_rd(ADDR_STATUS, 32'h0, RESP_OKAY);
    axi_rd(ADDR_MASK, 32'h0, RESP_OKAY);
    axi_rd(ADDR_LANES, 32'h0, RESP_OKAY);
    axi_rd(8'h10, 32'h0, RESP_SLVERR);
    axi_wr(8'h14, 32'h1, RESP_SLVERR);
    $display("reset and bus test done");
    @(negedge ref_clk);
    prev = divclk;
    {hi, tr} = '0;
    for (i = 0; i < 24; i++) begin
      @(negedge ref_clk);
      hi += int'(divclk);
      tr += int'(divclk != prev);
      prev = divclk;
    end
    check(hi, 12);
    check(tr, 4);
    for (i = 0; i < 16; i++) begin
      @(posedge ref_clk);
      prev = lreq;
      seed = next_rand(seed);
      lreq <= seed[0];
      @(negedge ref_clk);
      check(32'(lflag), 32'(prev));
    end
    $display("divider and local cycle test done");
    for (i = 0; i < 6; i++) begin
      seed = next_rand(seed);
      @(posedge ref_clk);
      sel <= seed[3:0];
      ale <= (i < 3);
      if (i < 3) ln = seed[3:0];
      repeat (2) @(negedge ref_clk);
      check(32'(lanes), 32'(ln));
    end
    @(posedge ref_clk);
    frc <= 1'b1; // only for an all-lane operation
    @(negedge ref_clk);
    check(32'(lanes), 32'hf);
    @(posedge ref_clk);
    frc <= 1'b0;
    @(negedge ref_clk);
    check(32'(lanes), 32'(ln));
    axi_wr(ADDR_CTRL, 32'h7, RESP_OKAY);
    axi_rd(ADDR_CTRL, 32'h7, RESP_OKAY);
    @(negedge ref_clk);
    check(32'(lanes), 32'hf);
    check(32'(mp_oe), 32'hf);
    axi_wr(ADDR_CTRL, 32'h0, RESP_OKAY);
    $display("lane select test done");
    w = next_rand(seed);
    @(posedge ref_clk);
    data <= w;
    @(negedge ref_clk);
    check(32'(mp_oe), 32'h0);
    @(posedge ref_clk);
    wgate <= 1'b1;
    store <= 1'b1;
    @(negedge ref_clk);
    check(32'(mp_oe), 32'hf);
    check(32'(mp_out), 32'(byte_par(w)));
    @(posedge ref_clk);
    store  <= 1'b0;
    rd_cyc <= 1'b1;
    @(negedge ref_clk);
    check(32'(mp_oe), 32'h0);
    @(posedge ref_clk);
    wgate <= 1'b0;
    $display("write parity test done");
    for (i = 0; i < 4; i++) begin
      seed = next_rand(seed);
      fl = (i < 2) ? 4'h4 : seed[3:0];
      ln = (i == 0) ? 4'hb : ((i == 1) ? 4'h4 : seed[7:4]);
      @(posedge ref_clk);
      sel  <= ln;
      ale  <= 1'b1;
      flip <= fl;
      data <= w;
      {cstb, sstb} <= 2'b11;
      @(posedge ref_clk);
      // disturb live inputs: only the captured copies may count
      {ale, cstb, sstb} <= 3'b000;
      data  <= seed;
      flip  <= ~fl;
      pgate <= 1'b1;
      repeat (3) @(negedge ref_clk);
      check(32'(fault), 32'(|(fl & ln)));
      @(posedge ref_clk);
      pgate <= 1'b0;
      repeat (2) @(negedge ref_clk);
      check(32'(fault), 32'h0);
    end
    @(posedge ref_clk);
    rd_cyc <= 1'b0;
    axi_rd(ADDR_STATUS, 32'h3, RESP_OKAY);
    axi_wr(ADDR_MASK, 32'h1, RESP_OKAY);
    @(negedge ref_clk);
    check(32'(irq), 32'h1);
    axi_wr(ADDR_MASK, 32'h0, RESP_OKAY);
    @(negedge ref_clk);
    check(32'(irq), 32'h0);
    axi_wr(ADDR_MASK, 32'h3, RESP_OKAY);
    axi_wr(ADDR_STATUS, 32'h3, RESP_OKAY);
    @(negedge ref_clk);
    check(32'(irq), 32'h0);
    axi_rd(ADDR_STATUS, 32'h0, RESP_OKAY);
    repeat (3) @(posedge ref_clk);
    $display("read check and interrupt test done");
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
